// ### rtl/hjd_top.sv
// Purpose: Headset jack watch, load probing and interrupt pin with AHB-Lite registers
// Assumes: Analog comparators deliver levels; pins pass a three-stage synchroniser
// Notes:   Interrupt pin is open drain; it is never driven high
//
// Design decisions made here: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module hjd_top #(
   parameter int unsigned TICK_CYCLES = hjd_pkg::TICK_CYCLES
) (
   input  wire logic        ref_clk,
   input  wire logic        reset_n,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic      [31:0] hrdata,
   input  wire logic        left_mic_above_high,
   input  wire logic        left_mic_above_low,
   input  wire logic        right_mic_above_high,
   input  wire logic        right_mic_above_low,
   input  wire logic        left_phone_low,
   input  wire logic        right_phone_low,
   input  wire logic        battery_supply_pin,
   input  wire logic        analog_supply_ok,
   output logic             irq_out,
   output logic             irq_oe,
   output logic             left_mic_watch_bias,
   output logic             left_mic_bias_on,
   output logic             right_mic_bias_on,
   output logic             phone_sense_pullup,
   output logic             right_phone_pulldown,
   output logic             probe_active
);
   localparam int NPIN    = 8;
   localparam int P_LHI   = 0;
   localparam int P_LLO   = 1;
   localparam int P_RHI   = 2;
   localparam int P_RLO   = 3;
   localparam int P_LPH   = 4;
   localparam int P_RPH   = 5;
   localparam int P_BAT   = 6;
   localparam int P_SUP   = 7;

   logic [NPIN-1:0]      pin_raw;
   logic [NPIN-1:0]      s1_q;
   logic [NPIN-1:0]      s2_q;
   logic [NPIN-1:0]      s3_q;
   logic [NPIN-1:0]      pin_q;
   logic                 bat_prev_q;
   logic                 sup_prev_q;
   logic [14:0]          tick_cnt_q;
   logic                 tick_q;
   hjd_pkg::hjd_mode_type mode_q;
   hjd_pkg::hjd_mode_type mode_prev_q;
   logic                 probe_on_q;
   logic                 sleep_q;
   logic [1:0]           test_sel_q;
   logic                 cfg_mask_q;
   logic                 bias_on_q;
   logic                 left_pow_q;
   logic                 right_pow_q;
   logic [5:0]           code_raw;
   logic [5:0]           code_q;
   logic                 deb_change;
   logic                 deb_left_change;
   logic [5:0]           charge_cnt_q;
   logic                 charge_q;
   logic                 watch_irq_q;
   logic                 jack_evt_q;
   logic                 cfg_flag_q;
   logic                 accept;
   logic                 stat0_rd;
   logic                 dp_wr_q;
   logic [31:0]          dp_addr_q;
   logic                 watch_cond;
   logic                 phone_bias_on;

   function automatic logic reg_hit(input logic [31:0] addr, input logic [5:0] idx);
      reg_hit = (addr == {24'h000000, idx, 2'b00});
   endfunction

   // Two comparator levels give the three-state mic class
   function automatic logic [1:0] mic_class(input logic above_hi, input logic above_lo);
      if (above_hi) begin
         mic_class = hjd_pkg::MIC_HIGH;
      end else if (above_lo) begin
         mic_class = hjd_pkg::MIC_MID;
      end else begin
         mic_class = hjd_pkg::MIC_LOW;
      end
   endfunction

   assign pin_raw = {analog_supply_ok, battery_supply_pin, right_phone_low, left_phone_low,
                     right_mic_above_low, right_mic_above_high,
                     left_mic_above_low, left_mic_above_high};

   // A level counts only once the second and third stages agree
   for (genvar i = 0; i < NPIN; i++) begin : g_sync
      always_ff @(posedge ref_clk or negedge reset_n) begin
         if (!reset_n) begin
            s1_q[i]  <= 1'b0;
            s2_q[i]  <= 1'b0;
            s3_q[i]  <= 1'b0;
            pin_q[i] <= 1'b0;
         end else begin
            s1_q[i] <= pin_raw[i];
            s2_q[i] <= s1_q[i];
            s3_q[i] <= s2_q[i];
            if (s2_q[i] == s3_q[i]) begin
               pin_q[i] <= s3_q[i];
            end
         end
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         tick_cnt_q <= 15'h0000;
         tick_q     <= 1'b0;
      end else if (tick_cnt_q == 15'(TICK_CYCLES - 1)) begin
         tick_cnt_q <= 15'h0000;
         tick_q     <= 1'b1;
      end else begin
         tick_cnt_q <= tick_cnt_q + 15'h0001;
         tick_q     <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         bat_prev_q <= 1'b0;
         sup_prev_q <= 1'b0;
      end else begin
         bat_prev_q <= pin_q[P_BAT];
         sup_prev_q <= pin_q[P_SUP];
      end
   end

   // Watch holds whenever analog supply is missing or sleep is requested
   assign watch_cond = sleep_q || !pin_q[P_SUP];

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         mode_q      <= hjd_pkg::MODE_IDLE;
         mode_prev_q <= hjd_pkg::MODE_IDLE;
      end else begin
         mode_prev_q <= mode_q;
         case (mode_q)
            hjd_pkg::MODE_WATCH: begin
               if (!watch_cond) begin
                  mode_q <= probe_on_q ? hjd_pkg::MODE_PROBE : hjd_pkg::MODE_IDLE;
               end
            end
            hjd_pkg::MODE_IDLE,
            hjd_pkg::MODE_PROBE: begin
               if (watch_cond) begin
                  mode_q <= hjd_pkg::MODE_WATCH;
               end else begin
                  mode_q <= probe_on_q ? hjd_pkg::MODE_PROBE : hjd_pkg::MODE_IDLE;
               end
            end
            default: begin
               mode_q <= hjd_pkg::MODE_IDLE;
            end
         endcase
      end
   end

   assign phone_bias_on = (mode_q == hjd_pkg::MODE_PROBE) && (test_sel_q != hjd_pkg::TEST_OFF);

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         probe_active         <= 1'b0;
         phone_sense_pullup   <= 1'b0;
         right_phone_pulldown <= 1'b0;
         left_mic_watch_bias  <= 1'b0;
         left_mic_bias_on     <= 1'b0;
         right_mic_bias_on    <= 1'b0;
      end else begin
         probe_active         <= (mode_q == hjd_pkg::MODE_PROBE);
         phone_sense_pullup   <= phone_bias_on;
         right_phone_pulldown <= phone_bias_on && (test_sel_q == hjd_pkg::TEST_TWO);
         left_mic_watch_bias  <= (mode_q == hjd_pkg::MODE_WATCH);
         left_mic_bias_on     <= bias_on_q && left_pow_q && (mode_q != hjd_pkg::MODE_WATCH);
         right_mic_bias_on    <= bias_on_q && right_pow_q && (mode_q != hjd_pkg::MODE_WATCH);
      end
   end

   // Phone bits read high only while a sense bias is applied
   assign code_raw = {mic_class(pin_q[P_LHI], pin_q[P_LLO]),
                      pin_q[P_RPH] && phone_bias_on,
                      pin_q[P_LPH] && phone_bias_on,
                      mic_class(pin_q[P_RHI], pin_q[P_RLO])};

   hjd_debounce u_debounce (
      .ref_clk       (ref_clk),
      .reset_n       (reset_n),
      .en            (mode_q == hjd_pkg::MODE_PROBE),
      .tick          (tick_q),
      .raw           (code_raw),
      .code_q        (code_q),
      .change_q      (deb_change),
      .left_change_q (deb_left_change)
   );

   // Charge window restarts on battery arrival or on each watch entry
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         charge_q     <= 1'b0;
         charge_cnt_q <= 6'h00;
      end else if ((pin_q[P_BAT] && !bat_prev_q) ||
                   (mode_q == hjd_pkg::MODE_WATCH && mode_prev_q != hjd_pkg::MODE_WATCH)) begin
         charge_q     <= 1'b1;
         charge_cnt_q <= 6'h00;
      end else if (charge_q && tick_q) begin
         if (charge_cnt_q == 6'(hjd_pkg::CHARGE_MS - 1)) begin
            charge_q <= 1'b0;
         end else begin
            charge_cnt_q <= charge_cnt_q + 6'h01;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         watch_irq_q <= 1'b0;
      end else if (mode_q != hjd_pkg::MODE_WATCH || pin_q[P_LHI]) begin
         watch_irq_q <= 1'b0;
      end else if (!pin_q[P_LLO]) begin
         watch_irq_q <= 1'b1;
      end
   end

   // Set wins over the read clear so no event is lost
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         jack_evt_q <= 1'b0;
         cfg_flag_q <= 1'b0;
      end else begin
         jack_evt_q <= (deb_left_change && mode_q == hjd_pkg::MODE_PROBE) ||
                       (jack_evt_q && !stat0_rd);
         cfg_flag_q <= (deb_change && cfg_mask_q) || (cfg_flag_q && !stat0_rd);
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         irq_oe  <= 1'b0;
         irq_out <= 1'b0;
      end else begin
         irq_oe  <= watch_irq_q || charge_q || jack_evt_q || cfg_flag_q;
         irq_out <= 1'b0;
      end
   end

   assign accept   = hsel && hready && htrans[1];
   assign stat0_rd = accept && !hwrite && reg_hit(haddr, hjd_pkg::IDX_STATUS0);

   // Zero-wait slave: read data is sampled in the address phase
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         dp_wr_q   <= 1'b0;
         dp_addr_q <= 32'h00000000;
         hrdata    <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         dp_wr_q   <= accept && hwrite;
         if (accept) begin
            dp_addr_q <= haddr;
         end
         if (accept && !hwrite) begin
            hrdata <= 32'h00000000;
            if (reg_hit(haddr, hjd_pkg::IDX_STATUS0)) begin
               hrdata[hjd_pkg::STAT0_CFG_BIT] <= cfg_flag_q;
            end else if (reg_hit(haddr, hjd_pkg::IDX_STATUS1)) begin
               hrdata[5:0]                    <= code_q;
               hrdata[hjd_pkg::STAT1_ONE_BIT] <= 1'b1;
               hrdata[hjd_pkg::STAT1_AOK_BIT] <= pin_q[P_SUP];
            end else if (reg_hit(haddr, hjd_pkg::IDX_IRQ_EN)) begin
               hrdata[hjd_pkg::IRQEN_CFG_BIT] <= cfg_mask_q;
            end else if (reg_hit(haddr, hjd_pkg::IDX_MIC_MODE)) begin
               hrdata[hjd_pkg::MIC_BIAS_BIT] <= bias_on_q;
            end else if (reg_hit(haddr, hjd_pkg::IDX_DETECT)) begin
               hrdata[hjd_pkg::DET_PROBE_BIT] <= probe_on_q;
               hrdata[hjd_pkg::DET_SLEEP_BIT] <= sleep_q;
               hrdata[1:0]                    <= test_sel_q;
            end else if (reg_hit(haddr, hjd_pkg::IDX_SHUTDOWN)) begin
               hrdata[hjd_pkg::SHDN_LEFT_BIT]  <= left_pow_q;
               hrdata[hjd_pkg::SHDN_RIGHT_BIT] <= right_pow_q;
            end
         end
      end
   end

   // Power return clears sleep so the detector leaves watch
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         probe_on_q <= hjd_pkg::DETECT_RST[hjd_pkg::DET_PROBE_BIT];
         sleep_q    <= hjd_pkg::DETECT_RST[hjd_pkg::DET_SLEEP_BIT];
         test_sel_q <= hjd_pkg::DETECT_RST[1:0];
      end else begin
         if (dp_wr_q && reg_hit(dp_addr_q, hjd_pkg::IDX_DETECT)) begin
            probe_on_q <= hwdata[hjd_pkg::DET_PROBE_BIT];
            test_sel_q <= hwdata[hjd_pkg::DET_TEST_LSB +: 2];
            sleep_q    <= hwdata[hjd_pkg::DET_SLEEP_BIT];
         end
         if (pin_q[P_SUP] && !sup_prev_q) begin
            sleep_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         cfg_mask_q  <= hjd_pkg::IRQ_EN_RST[hjd_pkg::IRQEN_CFG_BIT];
         bias_on_q   <= hjd_pkg::MIC_MODE_RST[hjd_pkg::MIC_BIAS_BIT];
         left_pow_q  <= hjd_pkg::SHUTDOWN_RST[hjd_pkg::SHDN_LEFT_BIT];
         right_pow_q <= hjd_pkg::SHUTDOWN_RST[hjd_pkg::SHDN_RIGHT_BIT];
      end else if (dp_wr_q) begin
         if (reg_hit(dp_addr_q, hjd_pkg::IDX_IRQ_EN)) begin
            cfg_mask_q <= hwdata[hjd_pkg::IRQEN_CFG_BIT];
         end
         if (reg_hit(dp_addr_q, hjd_pkg::IDX_MIC_MODE)) begin
            bias_on_q <= hwdata[hjd_pkg::MIC_BIAS_BIT];
         end
         if (reg_hit(dp_addr_q, hjd_pkg::IDX_SHUTDOWN)) begin
            left_pow_q  <= hwdata[hjd_pkg::SHDN_LEFT_BIT];
            right_pow_q <= hwdata[hjd_pkg::SHDN_RIGHT_BIT];
         end
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   sequence watch_low_s;
      (mode_q == hjd_pkg::MODE_WATCH) && !pin_q[P_LLO] && !pin_q[P_LHI];
   endsequence
   sequence irq_raised_s;
      ##1 watch_irq_q ##1 irq_oe;
   endsequence

   watch_irq_a:    assert property (watch_low_s |-> irq_raised_s)
      else $error("watch low did not raise irq");
   watch_hold_a:   assert property (watch_irq_q && mode_q == hjd_pkg::MODE_WATCH &&
                                    !pin_q[P_LHI] |=> watch_irq_q)
      else $error("watch irq dropped early");
   no_probe_a:     assert property (mode_q == hjd_pkg::MODE_WATCH |=> !probe_active)
      else $error("probing during watch");
   charge_a:       assert property ($rose(mode_q == hjd_pkg::MODE_WATCH) |=> charge_q [*8])
      else $error("charge window missing");
   bias_off_a:     assert property (test_sel_q == hjd_pkg::TEST_OFF |=>
                                    !phone_sense_pullup && !right_phone_pulldown)
      else $error("phone bias with test off");
   test_two_a:     assert property (mode_q == hjd_pkg::MODE_PROBE &&
                                    test_sel_q == hjd_pkg::TEST_TWO |=>
                                    right_phone_pulldown && phone_sense_pullup)
      else $error("test two bias wrong");
   cfg_set_a:      assert property (deb_change && cfg_mask_q |=> cfg_flag_q ##1 irq_oe)
      else $error("config change not flagged");
   mask_gate_a:    assert property ($rose(cfg_flag_q) |-> $past(cfg_mask_q && deb_change))
      else $error("flag set without enable");
   jack_set_a:     assert property (deb_left_change && mode_q == hjd_pkg::MODE_PROBE
                                    |=> jack_evt_q ##1 irq_oe)
      else $error("jack event lost");
   read_clear_a:   assert property (stat0_rd && !deb_change && !deb_left_change
                                    |=> !cfg_flag_q && !jack_evt_q)
      else $error("status read did not clear");
   irq_sticky_a:   assert property (cfg_flag_q && !stat0_rd |=> cfg_flag_q ##1 irq_oe)
      else $error("irq released before read");
   drive_low_a:    assert property (!irq_out)
      else $error("irq driven high");
   sleep_exit_a:   assert property (!sleep_q && pin_q[P_SUP] && mode_q == hjd_pkg::MODE_WATCH
                                    |=> mode_q != hjd_pkg::MODE_WATCH)
      else $error("watch not left");
endmodule
`default_nettype wire

// ### shared/hjd_pkg.sv
// Purpose: Shared constants and types of the headset jack detect block
// Assumes: 20 MHz reference clock, one aligned 32-bit word per register
// Notes:   Register byte address is four times the register index
package hjd_pkg;
   localparam int unsigned CLOCK_HZ     = 20_000_000;
   localparam int unsigned TICK_US      = 1000;
   localparam int unsigned TICK_CYCLES  = CLOCK_HZ / (1_000_000 / TICK_US);
   localparam int unsigned CHARGE_MS    = 50;
   localparam int unsigned DEBOUNCE_MS  = 20;

   localparam logic [5:0] IDX_STATUS0   = 6'h00;
   localparam logic [5:0] IDX_STATUS1   = 6'h01;
   localparam logic [5:0] IDX_IRQ_EN    = 6'h02;
   localparam logic [5:0] IDX_MIC_MODE  = 6'h12;
   localparam logic [5:0] IDX_DETECT    = 6'h19;
   localparam logic [5:0] IDX_SHUTDOWN  = 6'h1b;

   localparam int STAT0_CFG_BIT  = 1;
   localparam int STAT1_ONE_BIT  = 6;
   localparam int STAT1_AOK_BIT  = 7;
   localparam int IRQEN_CFG_BIT  = 1;
   localparam int MIC_BIAS_BIT   = 1;
   localparam int DET_PROBE_BIT  = 3;
   localparam int DET_SLEEP_BIT  = 2;
   localparam int DET_TEST_LSB   = 0;
   localparam int SHDN_LEFT_BIT  = 1;
   localparam int SHDN_RIGHT_BIT = 0;

   localparam logic [7:0] IRQ_EN_RST   = 8'h00;
   localparam logic [7:0] MIC_MODE_RST = 8'h00;
   localparam logic [7:0] DETECT_RST   = 8'h00;
   localparam logic [7:0] SHUTDOWN_RST = 8'h00;

   localparam logic [1:0] TEST_OFF     = 2'h0;
   localparam logic [1:0] TEST_ONE     = 2'h1;
   localparam logic [1:0] TEST_TWO     = 2'h2;

   localparam logic [1:0] MIC_LOW      = 2'h3;
   localparam logic [1:0] MIC_MID      = 2'h1;
   localparam logic [1:0] MIC_HIGH     = 2'h0;

   typedef enum logic [1:0] {
      MODE_IDLE,
      MODE_WATCH,
      MODE_PROBE
   } hjd_mode_type;
endpackage

// ### rtl/hjd_debounce.sv
// Purpose: Hold-time filter for the six-bit load code
// Assumes: tick is a one-cycle pulse every millisecond
// Notes:   Code is frozen while en is low
`timescale 1ns/1ps
`default_nettype none
module hjd_debounce (
   input  wire logic       ref_clk,
   input  wire logic       reset_n,
   input  wire logic       en,
   input  wire logic       tick,
   input  wire logic [5:0] raw,
   output logic      [5:0] code_q,
   output logic            change_q,
   output logic            left_change_q
);
   logic [5:0] cand_q;
   logic [4:0] cnt_q;

   // Counter restarts on any difference, so glitches shorter than the window vanish
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         cand_q        <= 6'h00;
         cnt_q         <= 5'h00;
         code_q        <= 6'h00;
         change_q      <= 1'b0;
         left_change_q <= 1'b0;
      end else begin
         change_q      <= 1'b0;
         left_change_q <= 1'b0;
         if (!en) begin
            cand_q <= code_q;
            cnt_q  <= 5'h00;
         end else if (raw != cand_q) begin
            cand_q <= raw;
            cnt_q  <= 5'h00;
         end else if (cnt_q == 5'(hjd_pkg::DEBOUNCE_MS)) begin
            if (cand_q != code_q) begin
               code_q        <= cand_q;
               change_q      <= 1'b1;
               left_change_q <= (cand_q[5:4] != code_q[5:4]);
            end
         end else if (tick) begin
            cnt_q <= cnt_q + 5'h01;
         end
      end
   end
endmodule
`default_nettype wire

// ### tb/hjd_jack_model.sv
// Purpose: Headset jack and comparator model facing hjd_top
// Assumes: Bench sets the loads; design sets the sense drives
// Notes:   An unsensed phone line toggles, as a floating pin would
`timescale 1ns/1ps
`default_nettype none
module hjd_jack_model (
   input  wire logic       ref_clk,
   input  wire logic [1:0] lcls,
   input  wire logic [1:0] rcls,
   input  wire logic       st_l,
   input  wire logic       st_r,
   input  wire logic       mono,
   input  wire logic       l_bias,
   input  wire logic       r_bias,
   input  wire logic       sense_pu,
   input  wire logic       pulldn,
   output logic            lh,
   output logic            ll,
   output logic            rh,
   output logic            rl,
   output logic            lp,
   output logic            rp
);
   logic t_q = 1'b0;
   always @(posedge ref_clk) t_q <= ~t_q;
   // Unbiased mic pins sit at ground
   assign lh = l_bias & (lcls == hjd_pkg::MIC_HIGH);
   assign ll = l_bias & (lcls != hjd_pkg::MIC_LOW);
   assign rh = r_bias & (rcls == hjd_pkg::MIC_HIGH);
   assign rl = r_bias & (rcls != hjd_pkg::MIC_LOW);
   assign lp = sense_pu ? (st_l | (pulldn & mono)) : t_q;
   assign rp = sense_pu ? (st_r | pulldn) : ~t_q;
endmodule
`default_nettype wire

// ### tb/headset_jack_detect_bench.sv
// Purpose: Self-checking bench for hjd_top
// Assumes: Short tick of 4 cycles, so 20 ms is 80 cycles
// Notes:   Reads queue their expectation; a monitor compares
`timescale 1ns/1ps
`default_nettype none
module headset_jack_detect_bench;
   localparam int unsigned TICKS = 4;
   logic        ref_clk = 1'b0, reset_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic        aok = 1'b0, st_l = 1'b0, st_r = 1'b0, mono = 1'b0;
   logic [1:0]  htrans = 2'h0, lcls = 2'h0, rcls = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic        hreadyout, hresp, irq_out, irq_oe, lwb, lbo, rbo, pu, pd, pa;
   logic        lh, ll, rh, rl, lp, rp;
   logic [31:0] exp_q[$];
   logic        rd_dp = 1'b0;
   int          failures = 0, cmp_count = 0, seed = 45;
   hjd_top #(.TICK_CYCLES(TICKS)) i_hjd_top (.ref_clk(ref_clk), .reset_n(reset_n),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .left_mic_above_high(lh), .left_mic_above_low(ll),
      .right_mic_above_high(rh), .right_mic_above_low(rl), .left_phone_low(lp),
      .right_phone_low(rp), .battery_supply_pin(reset_n), .analog_supply_ok(aok),
      .irq_out(irq_out), .irq_oe(irq_oe), .left_mic_watch_bias(lwb),
      .left_mic_bias_on(lbo), .right_mic_bias_on(rbo), .phone_sense_pullup(pu),
      .right_phone_pulldown(pd), .probe_active(pa));
   hjd_jack_model i_hjd_jack_model (.ref_clk(ref_clk), .lcls(lcls), .rcls(rcls),
      .st_l(st_l), .st_r(st_r), .mono(mono), .l_bias(lbo | lwb), .r_bias(rbo),
      .sense_pu(pu), .pulldn(pd), .lh(lh), .ll(ll), .rh(rh), .rl(rl), .lp(lp), .rp(rp));
   initial forever #25 ref_clk = ~ref_clk;
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   // Values are taken at the edge, so they are those settled in the cycle before it
   task automatic pin(input string n, input logic s, input logic e);
      chk(n, {31'h0, s}, {31'h0, e});
   endtask
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      bus(1'b0, a, 32'h0);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // Read data is taken at the edge that closes its data phase
   initial forever begin
      @(posedge ref_clk);
      if (rd_dp && hreadyout === 1'b1) begin
         chk("hrdata", hrdata, exp_q.pop_front());
      end
      if (hreadyout === 1'b1) begin
         rd_dp = hsel && htrans[1] && !hwrite;
      end
   end
   initial begin
      #2_000_000;
      failures++;
      tally_and_finish();
   end
   initial begin
      cyc(3);
      reset_n <= 1'b1;
      cyc(20);
      pin("irq_oe", irq_oe, 1'b1);
      pin("probe_active", pa, 1'b0);
      cyc(300);
      rd(32'h0, 32'h0);
      pin("irq_oe", irq_oe, 1'b0);
      lcls <= hjd_pkg::MIC_LOW;
      cyc(10);
      pin("irq_oe", irq_oe, 1'b1);
      rd(32'h0, 32'h0);
      pin("irq_oe", irq_oe, 1'b1);
      lcls <= hjd_pkg::MIC_HIGH;
      cyc(10);
      pin("irq_oe", irq_oe, 1'b0);
      aok <= 1'b1;
      bus(1'b1, 32'h48, 32'h2);
      bus(1'b1, 32'h6c, 32'h3);
      bus(1'b1, 32'h8, 32'h2);
      bus(1'b1, 32'h64, 32'h9);
      {lcls, st_l, st_r} <= {hjd_pkg::MIC_MID, 2'h3};
      cyc(200);
      pin("probe_active", pa, 1'b1);
      pin("irq_oe", irq_oe, 1'b1);
      rd(32'h4, 32'hdc);
      rd(32'h0, 32'h2);
      rd(32'h0, 32'h0);
      pin("irq_oe", irq_oe, 1'b0);
      {st_l, st_r, mono} <= 3'h1;
      cyc(40);
      rd(32'h4, 32'hdc);
      rd(32'h0, 32'h0);
      cyc(160);
      rd(32'h4, 32'hd0);
      // Test two only after both phone lines read low
      bus(1'b1, 32'h64, 32'ha);
      cyc(200);
      pin("right_phone_pulldown", pd, 1'b1);
      rd(32'h4, 32'hdc);
      bus(1'b1, 32'h64, 32'h8);
      cyc(200);
      pin("phone_sense_pullup", pu, 1'b0);
      rd(32'h4, 32'hd0);
      bus(1'b1, 32'h8, 32'h0);
      rd(32'h0, 32'h2);
      rcls <= hjd_pkg::MIC_MID;
      cyc(200);
      pin("irq_oe", irq_oe, 1'b0);
      rd(32'h0, 32'h0);
      rd(32'h4, 32'hd1);
      bus(1'b1, 32'h80, $random(seed));
      rd(32'h80, 32'h0);
      pin("irq_out", irq_out, 1'b0);
      pin("hresp", hresp, 1'b0);
      // Bias off first so it cannot load the watched pin
      bus(1'b1, 32'h48, 32'h0);
      bus(1'b1, 32'h64, 32'h4);
      cyc(10);
      pin("left_mic_watch_bias", lwb, 1'b1);
      pin("irq_oe", irq_oe, 1'b1);
      pin("probe_active", pa, 1'b0);
      bus(1'b1, 32'h64, 32'h8);
      cyc(10);
      pin("left_mic_watch_bias", lwb, 1'b0);
      pin("probe_active", pa, 1'b1);
      wait (exp_q.size() == 0);
      tally_and_finish();
   end
endmodule
`default_nettype wire
